// ===== shared/wdr_consts.svh
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH
`define WDR_CNT_W 16
`define WDR_CNT_INIT 16'hffff
`define WDR_CNT_ZERO 16'h0000
`define WDR_CNT_STEP 16'h0001
`define WDR_PC_W 14
`define WDR_START_ADDR 14'h0000
`define WDR_SYNC_W 3
`define WDR_SYNC_INIT 3'h1
`define WDR_SRC_PIN 0
`define WDR_SRC_POR 1
`define WDR_SRC_VDROP 2
`define WDR_CLK_MHZ 40
`define WDR_DRIVE_NS 1000
`define WDR_DRIVE_W 8
`endif

// ===== shared/wdr_pkg.sv
`include "wdr_consts.svh"
package wdr_pkg;
   typedef enum logic [1:0] {WDR_ST_RUN, WDR_ST_DRIVE, WDR_ST_HOLD} wdr_rst_state_type;
   typedef logic [`WDR_CNT_W-1:0] wdr_count_type;
endpackage : wdr_pkg

// ===== shared/wdr_core_if.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
interface wdr_core_if;
   logic cnt_pulse;
   logic cnt_reload;
   wdr_pkg::wdr_count_type cnt_value;
   logic cnt_underflow;
   logic [`WDR_SYNC_W-1:0] pins_raw;
   logic [`WDR_SYNC_W-1:0] pins_clean;
   modport cnt_side (input cnt_pulse, input cnt_reload, output cnt_value, output cnt_underflow);
   modport sync_side (input pins_raw, output pins_clean);
endinterface : wdr_core_if

// ===== design/wdr_wdog_counter.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_wdog_counter (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   wdr_core_if.cnt_side cnt
);
   wdr_pkg::wdr_count_type value_reg;
   wdr_pkg::wdr_count_type value_next;
   logic at_zero;

   assign at_zero = (value_reg == `WDR_CNT_ZERO);
   assign cnt.cnt_underflow = cnt.cnt_pulse && at_zero;
   // Zero minus one wraps straight to all ones, so counting does not stop at zero.
   assign value_next = cnt.cnt_reload ? `WDR_CNT_INIT : value_reg - `WDR_CNT_STEP;
   assign cnt.cnt_value = value_reg;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         value_reg <= `WDR_CNT_INIT;
      end
      else if (clk_en && (cnt.cnt_reload || cnt.cnt_pulse))
      begin
         value_reg <= value_next;
      end
   end

   a_counter_step: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && cnt.cnt_pulse && !cnt.cnt_reload && !at_zero
      |=> value_reg == $past(value_reg) - `WDR_CNT_STEP)
      else $error("Watchdog counter did not step down by one.");
   a_counter_wrap: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && cnt.cnt_underflow && !cnt.cnt_reload |=> value_reg == `WDR_CNT_INIT)
      else $error("Watchdog counter did not wrap to all ones.");
endmodule : wdr_wdog_counter

// ===== design/wdr_pin_sync.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_pin_sync (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   wdr_core_if.sync_side syn
);
   localparam logic [`WDR_SYNC_W-1:0] SYNC_INIT = `WDR_SYNC_INIT;
   logic [`WDR_SYNC_W-1:0] ff1_reg;
   logic [`WDR_SYNC_W-1:0] ff2_reg;
   logic [`WDR_SYNC_W-1:0] ff3_reg;
   logic [`WDR_SYNC_W-1:0] clean_reg;

   genvar i;
   generate
      for (i = 0; i < `WDR_SYNC_W; i = i + 1)
      begin : g_bit
         // A level is accepted only once the second and third stages agree.
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               ff1_reg[i] <= SYNC_INIT[i];
               ff2_reg[i] <= SYNC_INIT[i];
               ff3_reg[i] <= SYNC_INIT[i];
               clean_reg[i] <= SYNC_INIT[i];
            end
            else if (clk_en)
            begin
               ff1_reg[i] <= syn.pins_raw[i];
               ff2_reg[i] <= ff1_reg[i];
               ff3_reg[i] <= ff2_reg[i];
               if (ff2_reg[i] == ff3_reg[i])
               begin
                  clean_reg[i] <= ff3_reg[i];
               end
            end
         end
      end
   endgenerate

   assign syn.pins_clean = clean_reg;

   a_sync_agree: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && (ff2_reg == ff3_reg) |=> clean_reg == $past(ff3_reg))
      else $error("Synchronised level did not follow agreeing stages.");
endmodule : wdr_pin_sync

// ===== design/wdr_top.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic instr_clk_pulse,
   input wire logic instr_valid,
   input wire logic wdog_restart_instr,
   input wire logic wdog_disable_instr,
   input wire logic software_reset_instr,
   input wire logic ram_backup_entry,
   input wire logic reset_pin_in,
   input wire logic power_on_det,
   input wire logic vdrop_det,
   output logic reset_pin_out,
   output logic reset_pin_oe_n,
   output logic system_reset,
   output logic osc_stop,
   output logic exec_start,
   output logic [`WDR_PC_W-1:0] exec_start_addr,
   output logic skip_next_instr,
   output logic wdog_enable_flag,
   output logic wdog_first_timeout_flag,
   output logic wdog_second_timeout_flag,
   output logic port_init_hold,
   output logic port_c_pwm_pin_out,
   output logic port_c_pwm_pin_oe_n
);
   localparam int DRIVE_CYC = (`WDR_DRIVE_NS * `WDR_CLK_MHZ + 999) / 1000;
   localparam logic [`WDR_DRIVE_W-1:0] DRIVE_LAST = `WDR_DRIVE_W'(DRIVE_CYC - 1);
   localparam logic [`WDR_DRIVE_W-1:0] DRIVE_ONE = `WDR_DRIVE_W'(1);

   wdr_pkg::wdr_rst_state_type state_reg;
   wdr_pkg::wdr_rst_state_type state_next;
   logic [`WDR_DRIVE_W-1:0] drive_cnt_reg;
   logic [`WDR_DRIVE_W-1:0] drive_cnt_next;
   logic system_reset_reg;
   logic system_reset_next;
   logic wdog_first_flag_reg;
   logic wdog_first_flag_next;
   logic wdog_second_flag_reg;
   logic wdog_second_flag_next;
   logic wdog_enable_reg;
   logic wdog_enable_next;
   logic disable_pend_reg;
   logic disable_pend_next;
   logic skip_reg;
   logic exec_start_reg;
   logic [`WDR_PC_W-1:0] exec_start_addr_reg;
   logic reset_pin_out_reg;
   logic reset_pin_oe_n_reg;
   logic osc_stop_reg;
   logic port_init_hold_reg;
   logic port_c_pwm_pin_out_reg;
   logic port_c_pwm_pin_oe_n_reg;

   logic live_w;
   logic instr_w;
   logic restart_w;
   logic swrst_w;
   logic reinit_w;
   logic underflow_w;
   logic trip_w;
   logic ext_src_w;
   logic drive_req_w;
   logic release_w;
   logic skip_w;

   wdr_core_if core_if ();

   wdr_wdog_counter u_counter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .cnt(core_if)
   );

   wdr_pin_sync u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .syn(core_if)
   );

   assign core_if.pins_raw = {vdrop_det, power_on_det, reset_pin_in};

   assign live_w = !system_reset_reg;
   assign instr_w = instr_valid && live_w;
   assign restart_w = instr_w && wdog_restart_instr;
   assign swrst_w = instr_w && software_reset_instr;
   assign reinit_w = system_reset_reg || (ram_backup_entry && live_w);
   assign core_if.cnt_reload = reinit_w;
   assign core_if.cnt_pulse = instr_clk_pulse && wdog_enable_reg && !reinit_w;
   assign underflow_w = core_if.cnt_underflow;
   assign trip_w = underflow_w && wdog_first_flag_reg;
   assign ext_src_w = !core_if.pins_clean[`WDR_SRC_PIN] || core_if.pins_clean[`WDR_SRC_POR]
      || core_if.pins_clean[`WDR_SRC_VDROP];
   assign drive_req_w = trip_w || swrst_w;
   assign skip_w = restart_w && wdog_first_flag_reg;

   // A hardware set outranks the restart clear in the same cycle.
   assign wdog_first_flag_next = reinit_w ? 1'b0 : underflow_w ? 1'b1
      : skip_w ? 1'b0 : wdog_first_flag_reg;
   assign wdog_second_flag_next = system_reset_reg ? 1'b0
      : trip_w ? 1'b1 : wdog_second_flag_reg;
   assign wdog_enable_next = reinit_w ? 1'b1
      : (disable_pend_reg && restart_w) ? 1'b0 : wdog_enable_reg;
   assign disable_pend_next = system_reset_reg ? 1'b0
      : instr_w ? wdog_disable_instr : disable_pend_reg;
   assign system_reset_next = (state_next != wdr_pkg::WDR_ST_RUN);
   assign release_w = (state_reg == wdr_pkg::WDR_ST_HOLD) && (state_next == wdr_pkg::WDR_ST_RUN);

   always_comb
   begin
      state_next = state_reg;
      drive_cnt_next = drive_cnt_reg;
      case (state_reg)
         wdr_pkg::WDR_ST_RUN:
         begin
            if (drive_req_w)
            begin
               state_next = wdr_pkg::WDR_ST_DRIVE;
               drive_cnt_next = '0;
            end
            else if (ext_src_w)
            begin
               state_next = wdr_pkg::WDR_ST_HOLD;
            end
         end
         wdr_pkg::WDR_ST_DRIVE:
         begin
            if (drive_cnt_reg == DRIVE_LAST)
            begin
               state_next = wdr_pkg::WDR_ST_HOLD;
            end
            else
            begin
               drive_cnt_next = drive_cnt_reg + DRIVE_ONE;
            end
         end
         wdr_pkg::WDR_ST_HOLD:
         begin
            if (!ext_src_w)
            begin
               state_next = wdr_pkg::WDR_ST_RUN;
            end
         end
         default:
         begin
            state_next = wdr_pkg::WDR_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= wdr_pkg::WDR_ST_HOLD;
         drive_cnt_reg <= '0;
         system_reset_reg <= 1'b1;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         drive_cnt_reg <= drive_cnt_next;
         system_reset_reg <= system_reset_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wdog_first_flag_reg <= 1'b0;
         wdog_second_flag_reg <= 1'b0;
         wdog_enable_reg <= 1'b1;
         disable_pend_reg <= 1'b0;
         skip_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         wdog_first_flag_reg <= wdog_first_flag_next;
         wdog_second_flag_reg <= wdog_second_flag_next;
         wdog_enable_reg <= wdog_enable_next;
         disable_pend_reg <= disable_pend_next;
         skip_reg <= skip_w;
      end
   end

   // The pin is only ever pulled low; a voltage drop stops the oscillator instead.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         exec_start_reg <= 1'b0;
         exec_start_addr_reg <= `WDR_START_ADDR;
         reset_pin_out_reg <= 1'b0;
         reset_pin_oe_n_reg <= 1'b1;
         osc_stop_reg <= 1'b0;
         port_init_hold_reg <= 1'b1;
         port_c_pwm_pin_out_reg <= 1'b0;
         port_c_pwm_pin_oe_n_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         exec_start_reg <= release_w;
         exec_start_addr_reg <= `WDR_START_ADDR;
         reset_pin_out_reg <= 1'b0;
         reset_pin_oe_n_reg <= (state_next != wdr_pkg::WDR_ST_DRIVE);
         osc_stop_reg <= core_if.pins_clean[`WDR_SRC_VDROP];
         port_init_hold_reg <= system_reset_next;
         port_c_pwm_pin_out_reg <= 1'b0;
         port_c_pwm_pin_oe_n_reg <= !system_reset_next;
      end
   end

   assign reset_pin_out = reset_pin_out_reg;
   assign reset_pin_oe_n = reset_pin_oe_n_reg;
   assign system_reset = system_reset_reg;
   assign osc_stop = osc_stop_reg;
   assign exec_start = exec_start_reg;
   assign exec_start_addr = exec_start_addr_reg;
   assign skip_next_instr = skip_reg;
   assign wdog_enable_flag = wdog_enable_reg;
   assign wdog_first_timeout_flag = wdog_first_flag_reg;
   assign wdog_second_timeout_flag = wdog_second_flag_reg;
   assign port_init_hold = port_init_hold_reg;
   assign port_c_pwm_pin_out = port_c_pwm_pin_out_reg;
   assign port_c_pwm_pin_oe_n = port_c_pwm_pin_oe_n_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_count_start: assert property (
      exec_start_reg |-> core_if.cnt_value == `WDR_CNT_INIT)
      else $error("Counter not at all ones at reset release.");
   a_first_flag_set: assert property (
      clk_en && underflow_w && !wdog_first_flag_reg |=> wdog_first_flag_reg)
      else $error("First timeout flag not set on underflow.");
   a_second_flag_trip: assert property (
      clk_en && trip_w |=> wdog_second_flag_reg && !reset_pin_oe_n_reg)
      else $error("Second underflow did not trip the watchdog reset.");
   a_pin_drive_hold: assert property (
      $fell(reset_pin_oe_n_reg) |-> (!reset_pin_oe_n_reg && system_reset_reg) [*8])
      else $error("Reset pin drive was cut short.");
   a_enable_set: assert property (
      clk_en && reinit_w |=> wdog_enable_reg)
      else $error("Enable flag not set by reset or back-up entry.");
   a_disable_pair: assert property (
      clk_en && disable_pend_reg && restart_w && !reinit_w |=> !wdog_enable_reg)
      else $error("Disable then restart did not clear the enable flag.");
   a_disable_alone: assert property (
      clk_en && instr_w && wdog_disable_instr && !disable_pend_reg && wdog_enable_reg
      ##1 clk_en && instr_w && !wdog_restart_instr |=> wdog_enable_reg)
      else $error("Watchdog stopped without a following restart.");
   a_restart_skip: assert property (
      clk_en && skip_w && !underflow_w && !reinit_w |=> skip_reg && !wdog_first_flag_reg)
      else $error("Restart with flag set did not clear and skip.");
   a_restart_noskip: assert property (
      clk_en && restart_w && !wdog_first_flag_reg |=> !skip_reg)
      else $error("Restart with flag clear caused a skip.");
   a_skip_disabled: assert property (
      clk_en && !wdog_enable_reg && restart_w && wdog_first_flag_reg |=> skip_reg)
      else $error("Skip lost while watchdog disabled.");
   a_backup_reinit: assert property (
      clk_en && ram_backup_entry && live_w
      |=> !wdog_first_flag_reg && core_if.cnt_value == `WDR_CNT_INIT)
      else $error("Back-up entry did not reinitialise flag and counter.");
   a_pin_source: assert property (
      clk_en && live_w && !core_if.pins_clean[`WDR_SRC_PIN] && !drive_req_w |=> system_reset_reg)
      else $error("Low reset pin did not reset the system.");
   a_release_addr: assert property (
      $fell(system_reset_reg)
      |-> exec_start_reg && exec_start_addr_reg == `WDR_START_ADDR
      && core_if.pins_clean[`WDR_SRC_PIN])
      else $error("Release without start at address zero.");
   a_soft_reset: assert property (
      clk_en && swrst_w |=> !reset_pin_oe_n_reg && system_reset_reg)
      else $error("Software reset did not drive the pin low.");
   a_port_state: assert property (
      system_reset_reg |-> port_init_hold_reg && !port_c_pwm_pin_oe_n_reg
      && !port_c_pwm_pin_out_reg)
      else $error("Port reset state not held during reset.");
   a_flags_reset: assert property (
      clk_en && system_reset_reg |=> !wdog_first_flag_reg && !wdog_second_flag_reg)
      else $error("Timeout flags not cleared by system reset.");
   a_vdrop_quiet: assert property (
      clk_en && core_if.pins_clean[`WDR_SRC_VDROP] && (state_reg != wdr_pkg::WDR_ST_DRIVE)
      && !drive_req_w |=> system_reset_reg && reset_pin_oe_n_reg && osc_stop_reg)
      else $error("Voltage drop reset drove the pin or kept the oscillator.");

   c_watchdog_trip: cover property (clk_en && trip_w);
   c_disable_pair: cover property (clk_en && disable_pend_reg && restart_w);
   c_restart_skip: cover property (skip_reg);
   c_soft_reset: cover property (clk_en && swrst_w);
endmodule : wdr_top

// ===== sim/wdr_pin_model.sv
`timescale 1ns/1ps
// Models the open-drain reset pin with its pull-up and the external reset source.
module wdr_pin_model (
   input wire logic ext_low,
   input wire logic reset_pin_oe_n,
   output logic reset_pin_level
);
   wire logic dev_pull;
   assign dev_pull = (reset_pin_oe_n === 1'h0);
   // The pin reads low while either party pulls it, otherwise the pull-up wins.
   assign reset_pin_level = (dev_pull || ext_low) ? 1'h0 : 1'h1;
endmodule : wdr_pin_model

// ===== sim/watchdog_and_system_reset_tb.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module watchdog_and_system_reset_tb;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic clk_en = 1'h1;
   logic instr_clk_pulse = 1'h0;
   logic instr_valid = 1'h0;
   logic wdog_restart_instr = 1'h0;
   logic wdog_disable_instr = 1'h0;
   logic software_reset_instr = 1'h0;
   logic ram_backup_entry = 1'h0;
   logic power_on_det = 1'h0;
   logic vdrop_det = 1'h0;
   logic ext_low = 1'h0;
   logic reset_pin_level;
   logic reset_pin_out;
   logic reset_pin_oe_n;
   logic system_reset;
   logic osc_stop;
   logic exec_start;
   logic [`WDR_PC_W-1:0] exec_start_addr;
   logic skip_next_instr;
   logic wdog_enable_flag;
   logic wdog_first_timeout_flag;
   logic wdog_second_timeout_flag;
   logic port_init_hold;
   logic port_c_pwm_pin_out;
   logic port_c_pwm_pin_oe_n;
   int bad_count = 0;
   int checks_done = 0;

   wdr_top uut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .instr_clk_pulse(instr_clk_pulse),
      .instr_valid(instr_valid),
      .wdog_restart_instr(wdog_restart_instr),
      .wdog_disable_instr(wdog_disable_instr),
      .software_reset_instr(software_reset_instr),
      .ram_backup_entry(ram_backup_entry),
      .reset_pin_in(reset_pin_level),
      .power_on_det(power_on_det),
      .vdrop_det(vdrop_det),
      .reset_pin_out(reset_pin_out),
      .reset_pin_oe_n(reset_pin_oe_n),
      .system_reset(system_reset),
      .osc_stop(osc_stop),
      .exec_start(exec_start),
      .exec_start_addr(exec_start_addr),
      .skip_next_instr(skip_next_instr),
      .wdog_enable_flag(wdog_enable_flag),
      .wdog_first_timeout_flag(wdog_first_timeout_flag),
      .wdog_second_timeout_flag(wdog_second_timeout_flag),
      .port_init_hold(port_init_hold),
      .port_c_pwm_pin_out(port_c_pwm_pin_out),
      .port_c_pwm_pin_oe_n(port_c_pwm_pin_oe_n)
   );

   wdr_pin_model pin_model (
      .ext_low(ext_low),
      .reset_pin_oe_n(reset_pin_oe_n),
      .reset_pin_level(reset_pin_level)
   );

   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic f_skip(input logic f1, input logic rst);
      return f1 & rst;
   endfunction : f_skip

   function automatic logic [15:0] f_drive();
      return 16'(`WDR_DRIVE_NS * `WDR_CLK_MHZ / 1000);
   endfunction : f_drive

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task close_out;
      $display("Checks made: %0d, mismatches: %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic put(input logic v, input logic r, input logic d, input logic s);
      @(posedge core_clk);
      instr_valid <= v;
      wdog_restart_instr <= r;
      wdog_disable_instr <= d;
      software_reset_instr <= s;
   endtask : put

   task automatic wait_sys(input logic v);
      int n;
      n = 0;
      while (system_reset !== v && n < 12)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(system_reset, v);
   endtask : wait_sys

   initial
   begin
      repeat (80000) @(posedge core_clk);
      bad_count++;
      close_out();
   end

   initial
   begin
      int n;
      void'($urandom(29641));
      repeat (20) @(posedge core_clk);
      #1;
      chk(port_init_hold, 1'h1);
      chk(port_c_pwm_pin_oe_n, 1'h0);
      chk(port_c_pwm_pin_out, 1'h0);
      chk(wdog_enable_flag, 1'h1);
      chk({wdog_first_timeout_flag, wdog_second_timeout_flag}, 2'h0);
      @(posedge core_clk);
      sys_rst <= 1'h0;
      wait_sys(1'h0);
      chk(exec_start, 1'h1);
      chk(exec_start_addr, `WDR_START_ADDR);
      chk({port_init_hold, port_c_pwm_pin_oe_n}, 2'h1);
      put(1'h1, 1'h1, 1'h0, 1'h0);
      put(1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk(skip_next_instr, f_skip(1'h0, 1'h1));
      put(1'h1, 1'h0, 1'h1, 1'h0);
      put(1'h1, 1'h0, 1'h0, 1'h0);
      put(1'h1, 1'h1, 1'h0, 1'h0);
      put(1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk(wdog_enable_flag, 1'h1);
      put(1'h1, 1'h0, 1'h1, 1'h0);
      put(1'h1, 1'h1, 1'h0, 1'h0);
      put(1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk(wdog_enable_flag, 1'h0);
      repeat (2000)
      begin
         @(posedge core_clk);
         clk_en <= ($urandom_range(3, 0) != 32'h0);
         instr_valid <= 1'($urandom());
         wdog_restart_instr <= 1'($urandom());
         instr_clk_pulse <= 1'($urandom());
         #1;
         chk(skip_next_instr, f_skip(1'h0, 1'h1));
         chk({wdog_enable_flag, wdog_first_timeout_flag}, 2'h0);
      end
      @(posedge core_clk);
      clk_en <= 1'h1;
      instr_clk_pulse <= 1'h0;
      put(1'h1, 1'h1, 1'h0, 1'h0);
      put(1'h1, 1'h0, 1'h0, 1'h0);
      @(posedge core_clk);
      instr_valid <= 1'h0;
      wdog_restart_instr <= 1'h0;
      ram_backup_entry <= 1'h1;
      @(posedge core_clk);
      ram_backup_entry <= 1'h0;
      instr_clk_pulse <= 1'h1;
      #1;
      chk(wdog_enable_flag, 1'h1);
      chk(wdog_first_timeout_flag, 1'h0);
      repeat (65534) @(posedge core_clk);
      @(posedge core_clk);
      instr_clk_pulse <= 1'h0;
      #1;
      chk(wdog_first_timeout_flag, 1'h0);
      put(1'h1, 1'h0, 1'h1, 1'h0);
      // The disabling restart lands on the underflow edge with the flag still clear, so the flag sets and the enable clears.
      @(posedge core_clk);
      instr_clk_pulse <= 1'h1;
      instr_valid <= 1'h1;
      wdog_restart_instr <= 1'h1;
      wdog_disable_instr <= 1'h0;
      @(posedge core_clk);
      instr_clk_pulse <= 1'h0;
      instr_valid <= 1'h0;
      wdog_restart_instr <= 1'h0;
      #1;
      chk({wdog_first_timeout_flag, wdog_second_timeout_flag}, 2'h2);
      chk(wdog_enable_flag, 1'h0);
      chk(skip_next_instr, f_skip(1'h0, 1'h1));
      put(1'h1, 1'h1, 1'h0, 1'h0);
      put(1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk(skip_next_instr, f_skip(1'h1, 1'h1));
      chk(wdog_first_timeout_flag, 1'h0);
      @(posedge core_clk);
      #1;
      chk(skip_next_instr, 1'h0);
      put(1'h1, 1'h0, 1'h0, 1'h1);
      put(1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk({reset_pin_oe_n, reset_pin_out, system_reset}, 3'h1);
      chk({port_init_hold, port_c_pwm_pin_oe_n}, 2'h2);
      n = 0;
      while (reset_pin_oe_n === 1'h0 && n < 100)
      begin
         n++;
         @(posedge core_clk);
         #1;
      end
      chk(16'(n), f_drive());
      chk(wdog_enable_flag, 1'h1);
      chk({wdog_first_timeout_flag, wdog_second_timeout_flag}, 2'h0);
      wait_sys(1'h0);
      chk(exec_start, 1'h1);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge core_clk);
         ext_low <= (k == 0);
         power_on_det <= (k == 1);
         vdrop_det <= (k == 2);
         wait_sys(1'h1);
         chk(reset_pin_oe_n, 1'h1);
         chk(osc_stop, (k == 2));
         @(posedge core_clk);
         ext_low <= 1'h0;
         power_on_det <= 1'h0;
         vdrop_det <= 1'h0;
         wait_sys(1'h0);
         chk({exec_start, osc_stop}, 2'h2);
         chk(exec_start_addr, `WDR_START_ADDR);
      end
      close_out();
   end
endmodule : watchdog_and_system_reset_tb
